// ===== logic/vsx_pkg.sv
`default_nettype none
package vsx_pkg;

	// ****************************************************************
	// Register indexes
	// ****************************************************************
	localparam logic [4:0] IDX_FONT = 5'h03;
	localparam logic [4:0] IDX_MEMMODE = 5'h04;
	localparam logic [4:0] IDX_UNLOCK = 5'h08;
	localparam logic [4:0] IDX_MAPPED = 5'h09;
	localparam logic [4:0] IDX_PINWR = 5'h0A;
	localparam logic [4:0] IDX_COLOR = 5'h0B;
	localparam logic [4:0] IDX_SYNC = 5'h0D;
	localparam logic [4:0] IDX_PLL_LOW = 5'h10;
	localparam logic [4:0] IDX_EXT_FIRST = 5'h09;
	localparam logic [4:0] IDX_EXT_LAST = 5'h1C;

	// ****************************************************************
	// Reset values and writable masks
	// ****************************************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] MASK_FONT = 8'h3F;
	localparam logic [7:0] MASK_MEMMODE = 8'h0E;
	localparam logic [7:0] MASK_UNLOCK = 8'hFF;
	localparam logic [7:0] MASK_MAPPED = 8'h80;
	localparam logic [7:0] MASK_PINWR = 8'hE0;
	localparam logic [7:0] MASK_COLOR = 8'hFB;
	localparam logic [7:0] MASK_SYNC = 8'hF3;
	localparam logic [7:0] MASK_PLL_LOW = 8'h7F;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int B_FA_HI = 5;
	localparam int B_FA_MID = 3;
	localparam int B_FA_LO = 2;
	localparam int B_FB_HI = 4;
	localparam int B_FB_MID = 1;
	localparam int B_FB_LO = 0;
	localparam int B_FULL_MEM = 1;
	localparam int B_SEQ_ADDR = 2;
	localparam int B_CHAIN4 = 3;
	localparam int B_EXCLUSIVE = 7;
	localparam int B_DATA_DRIVE = 5;
	localparam int B_PIN50 = 6;
	localparam int B_FAST_WR = 7;
	localparam int B_DOT_EXT = 0;
	localparam int B_LATCH_EXT = 1;
	localparam int B_PACKED = 3;
	localparam int B_FMT_HI = 7;
	localparam int B_FMT_LO = 4;
	localparam int B_CONN_EN = 0;
	localparam int B_CONN_TYPE = 1;
	localparam int B_HS_HI = 5;
	localparam int B_HS_LO = 4;
	localparam int B_VS_HI = 7;
	localparam int B_VS_LO = 6;
	localparam int B_DIV_HI = 4;
	localparam int B_RANGE_HI = 6;
	localparam int B_RANGE_LO = 5;

	// ****************************************************************
	// Codes
	// ****************************************************************
	localparam logic [3:0] UNLOCK_KEY = 4'h6;
	localparam logic [3:0] PIXMODE_PLAIN = 4'h0;
	localparam logic [1:0] WR_CLKS_SLOW = 2'h3;
	localparam logic [1:0] WR_CLKS_FAST = 2'h2;
	localparam logic [3:0] PLANES_ALL = 4'hF;
	localparam logic [3:0] PLANES_EVEN = 4'h5;
	localparam logic [3:0] PLANES_ODD = 4'hA;
	typedef enum logic [3:0] {
		FMT_8BIT_1PIX = 4'h0,
		FMT_8BIT_2PIX = 4'h1,
		FMT_15BIT = 4'h3,
		FMT_16BIT = 4'h5,
		FMT_PACKED_24 = 4'h7,
		FMT_24BIT = 4'hD
	} vsx_fmt_e;
	typedef enum logic [1:0] {
		SYNC_NORMAL = 2'h0,
		SYNC_FORCE_LOW = 2'h1,
		SYNC_FORCE_HIGH = 2'h2,
		SYNC_RESERVED = 2'h3
	} vsx_sync_e;

endpackage
`default_nettype wire

// ===== logic/vsx_sync_force.sv
`default_nettype none
module vsx_sync_force (
	input wire logic clock_i,        // System clock
	input wire logic reset_i,        // Async reset, active high
	input wire logic [1:0] ctl_i,    // Force code
	input wire logic sync_i,         // Sync from timing logic
	output logic sync_o              // Sync to pin
);
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			sync_o <= 1'b0;
		end else begin
			case (ctl_i)
				vsx_pkg::SYNC_FORCE_LOW: sync_o <= 1'b0;
				vsx_pkg::SYNC_FORCE_HIGH: sync_o <= 1'b1;
				default: sync_o <= sync_i;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== logic/vsx_seq_regs.sv
// Overview of operation
// - Attribute bit 3 switches fonts in text mode when selects differ
// - Font B bits 4,1,0 pick 8K region
// - Font A bits 5,3,2 pick 8K region
// - Without full memory only regions 0, 4
// - Font select clears asynchronously on reset
// - Full memory bit opens whole 256K
// - Sequential bit: writes only, chain-4 clear
// - Chain-4 selects plane from A1 A0
// - Low nibble 0110 unlocks extended registers
// - Exclusive bit blocks port accesses under mapping
// - Data drive bit keeps memory pins driven
// - Pin fifty carries output enable, row strobe, or high on EDO with legacy connector
// - Fast write bit gives two-clock writes
// - Test bit runs dot clock externally
// - Latch bit picks connector latch clock
// - Packed truecolor needs enable and both modes
// - Connector pixel format decode, others reserved
// - Connector enable drives pin and directions
// - Connector type acts with bus off, enabled
// - Sync fields force low, high or normal
// - PLL low divider loads on load permission
`default_nettype none
module vsx_seq_regs #(
	parameter logic [7:0] PLL_LOW_RESET = 8'h01, // Plain default
	parameter int PIN_COUNT = 64,
	parameter int HOLD_FROM = 29
) (
	input wire logic clock_i,                  // System clock
	input wire logic reset_i,                  // Async reset, active high
	input wire logic io_write_i,               // Port write strobe
	input wire logic io_read_i,                // Port read strobe
	input wire logic io_data_port_i,           // 0 index port, 1 data port
	input wire logic io_word_i,                // Word write at index port
	input wire logic [7:0] io_wdata_i,         // Write data low byte
	input wire logic [7:0] io_wdata_hi_i,      // Write data high byte
	input wire logic io_mapped_i,              // Access came memory-mapped
	input wire logic mapped_enable_i,          // Memory mapping enabled
	output logic [7:0] io_rdata_o,             // Read data
	output logic io_rvalid_o,                  // Read data valid pulse
	input wire logic text_mode_i,              // Text mode active
	input wire logic attr_bit3_i,              // Attribute byte bit 3
	output logic [2:0] font_region_o,          // 8K region of plane 2
	output logic font_intensity_o,             // Bit 3 as intensity
	input wire logic [1:0] cpu_addr_i,         // CPU address A1 A0
	input wire logic cpu_write_i,              // CPU access is a write
	output logic [3:0] plane_select_o,         // Planes reached
	output logic full_memory_access_o,         // 256K window open
	input wire logic [PIN_COUNT-1:0] mem_out_i, // Data for memory pins
	input wire logic mem_out_req_i,            // Output needed now
	output logic [PIN_COUNT-1:0] memory_data_pins_o, // Pin data
	output logic [PIN_COUNT-1:0] memory_data_pins_oe_o, // Pin enable
	input wire logic edo_memory_i,             // EDO memory fitted
	input wire logic output_enable_zero_i,     // Fast page enable
	input wire logic output_enable_one_i,      // EDO enable
	input wire logic second_row_strobe_i,      // Second row strobe
	output logic pin_fifty_o,                  // Pin fifty level
	output logic [1:0] write_cycle_clocks_o,   // Clocks per CPU write
	output logic external_dot_clock_test_o,    // Dot clock from input
	output logic connector_latch_clock_select_o, // Latch on input clock
	input wire logic [3:0] pixel_mode_i,       // Other pixel mode field
	output logic packed_truecolor_active_o,    // Packed 24-bit on
	output logic [3:0] connector_pixel_format_o, // Decoded format
	output logic connector_format_reserved_o,  // Reserved format code
	output logic connector_enable_pin_o,       // Connector enable pin
	input wire logic clock_direction_input_i,  // Low: clock is input
	input wire logic sync_direction_input_i,   // Low: syncs are input
	output logic video_clock_out_en_o,         // Video clock drives out
	output logic sync_out_en_o,                // Syncs drive out
	input wire logic local_peripheral_bus_i,   // Local bus enabled
	output logic connector_type_select_o,      // Local bus connector
	input wire logic hsync_i,                  // Horizontal sync
	input wire logic vsync_i,                  // Vertical sync
	output logic hsync_o,                      // Horizontal sync pin
	output logic vsync_o,                      // Vertical sync pin
	input wire logic freq_load_i,              // Frequency load enable
	input wire logic immediate_load_i,         // Immediate load
	output logic [4:0] pll_in_div_o,           // Active input divider
	output logic [1:0] pll_range_o             // Active output range
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (PLL_LOW_RESET[vsx_pkg::B_DIV_HI:0] == 5'h00) begin : g_chk_div
		$error("PLL divider reset value must be 1 to 31");
	end
	if (HOLD_FROM < 1 || HOLD_FROM >= PIN_COUNT) begin : g_chk_pins
		$error("Hold boundary must lie inside the pin range");
	end

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [4:0] index;
	logic [7:0] font_bank_select;
	logic [7:0] memory_addressing_mode;
	logic [7:0] extension_unlock;
	logic [7:0] mapped_access_control;
	logic [7:0] memory_pin_write_control;
	logic [7:0] connector_color_mode;
	logic [7:0] connector_sync_control;
	logic [7:0] memclk_pll_low;

	logic port_allowed;
	logic unlocked;
	logic ext_index;
	logic index_open;
	logic data_write;
	logic [7:0] data_value;
	logic [4:0] target;
	logic [7:0] next_rdata;

	// ****************************************************************
	// Access decode
	// ****************************************************************
	assign port_allowed = io_mapped_i || !mapped_enable_i
		|| !mapped_access_control[vsx_pkg::B_EXCLUSIVE];
	assign unlocked = extension_unlock[3:0] == vsx_pkg::UNLOCK_KEY;
	assign ext_index = target >= vsx_pkg::IDX_EXT_FIRST
		&& target <= vsx_pkg::IDX_EXT_LAST;
	assign index_open = !ext_index || unlocked;

	// Word write at the index port carries index low, data high
	assign target = (io_word_i && !io_data_port_i)
		? io_wdata_i[4:0] : index;
	assign data_value = io_data_port_i ? io_wdata_i : io_wdata_hi_i;
	assign data_write = io_write_i && port_allowed && index_open
		&& (io_data_port_i || io_word_i);

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			index <= 5'h00;
		end else if (io_write_i && port_allowed && !io_data_port_i) begin
			index <= io_wdata_i[4:0];
		end
	end

	// ****************************************************************
	// Register writes
	// ****************************************************************
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			font_bank_select <= vsx_pkg::RST_ZERO;
			memory_addressing_mode <= vsx_pkg::RST_ZERO;
			extension_unlock <= vsx_pkg::RST_ZERO;
			mapped_access_control <= vsx_pkg::RST_ZERO;
			memory_pin_write_control <= vsx_pkg::RST_ZERO;
			connector_color_mode <= vsx_pkg::RST_ZERO;
			connector_sync_control <= vsx_pkg::RST_ZERO;
			memclk_pll_low <= PLL_LOW_RESET;
		end else if (data_write) begin
			case (target)
				vsx_pkg::IDX_FONT:
					font_bank_select <= data_value
						& vsx_pkg::MASK_FONT;
				vsx_pkg::IDX_MEMMODE:
					memory_addressing_mode <= data_value
						& vsx_pkg::MASK_MEMMODE;
				vsx_pkg::IDX_UNLOCK:
					extension_unlock <= data_value
						& vsx_pkg::MASK_UNLOCK;
				vsx_pkg::IDX_MAPPED:
					mapped_access_control <= data_value
						& vsx_pkg::MASK_MAPPED;
				vsx_pkg::IDX_PINWR:
					memory_pin_write_control <= data_value
						& vsx_pkg::MASK_PINWR;
				vsx_pkg::IDX_COLOR:
					connector_color_mode <= data_value
						& vsx_pkg::MASK_COLOR;
				vsx_pkg::IDX_SYNC:
					connector_sync_control <= data_value
						& vsx_pkg::MASK_SYNC;
				vsx_pkg::IDX_PLL_LOW:
					memclk_pll_low <= data_value
						& vsx_pkg::MASK_PLL_LOW;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	always_comb begin
		next_rdata = vsx_pkg::RST_ZERO;
		if (!io_data_port_i) begin
			next_rdata = {3'h0, index};
		end else if (index_open) begin
			case (target)
				vsx_pkg::IDX_FONT: next_rdata = font_bank_select;
				vsx_pkg::IDX_MEMMODE: next_rdata = memory_addressing_mode;
				vsx_pkg::IDX_UNLOCK: next_rdata = extension_unlock;
				vsx_pkg::IDX_MAPPED: next_rdata = mapped_access_control;
				vsx_pkg::IDX_PINWR: next_rdata = memory_pin_write_control;
				vsx_pkg::IDX_COLOR: next_rdata = connector_color_mode;
				vsx_pkg::IDX_SYNC: next_rdata = connector_sync_control;
				vsx_pkg::IDX_PLL_LOW: next_rdata = memclk_pll_low;
				default: next_rdata = vsx_pkg::RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			io_rdata_o <= vsx_pkg::RST_ZERO;
			io_rvalid_o <= 1'b0;
		end else begin
			io_rvalid_o <= io_read_i;
			if (io_read_i) begin
				io_rdata_o <= port_allowed
					? next_rdata : vsx_pkg::RST_ZERO;
			end
		end
	end

	// ****************************************************************
	// Font selection
	// ****************************************************************
	logic [2:0] font_a_select;
	logic [2:0] font_b_select;
	logic [2:0] next_font;
	logic font_switch;

	// Table order: bits 1,0 give the high index bits, bit 4 the low one
	assign font_b_select = {font_bank_select[vsx_pkg::B_FB_MID],
		font_bank_select[vsx_pkg::B_FB_LO],
		font_bank_select[vsx_pkg::B_FB_HI]};
	assign font_a_select = {font_bank_select[vsx_pkg::B_FA_MID],
		font_bank_select[vsx_pkg::B_FA_LO],
		font_bank_select[vsx_pkg::B_FA_HI]};
	assign font_switch = text_mode_i
		&& font_a_select != font_b_select;

	always_comb begin
		next_font = font_a_select;
		if (font_switch && attr_bit3_i) begin
			next_font = font_b_select;
		end
		if (!memory_addressing_mode[vsx_pkg::B_FULL_MEM]) begin
			next_font = {next_font[2], 2'h0};
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			font_region_o <= 3'h0;
			font_intensity_o <= 1'b0;
		end else begin
			font_region_o <= next_font;
			font_intensity_o <= attr_bit3_i && !font_switch;
		end
	end

	// ****************************************************************
	// CPU plane addressing
	// ****************************************************************
	logic [3:0] next_planes;

	always_comb begin
		if (memory_addressing_mode[vsx_pkg::B_CHAIN4]) begin
			next_planes = 4'h1 << cpu_addr_i;
		end else if (cpu_write_i
			&& memory_addressing_mode[vsx_pkg::B_SEQ_ADDR]) begin
			next_planes = vsx_pkg::PLANES_ALL;
		end else if (cpu_addr_i[0]) begin
			next_planes = vsx_pkg::PLANES_ODD;
		end else begin
			next_planes = vsx_pkg::PLANES_EVEN;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			plane_select_o <= vsx_pkg::PLANES_EVEN;
			full_memory_access_o <= 1'b0;
		end else begin
			plane_select_o <= next_planes;
			full_memory_access_o <=
				memory_addressing_mode[vsx_pkg::B_FULL_MEM];
		end
	end

	// ****************************************************************
	// Memory data pins
	// ****************************************************************
	logic pins_drive;

	assign pins_drive = mem_out_req_i
		|| memory_pin_write_control[vsx_pkg::B_DATA_DRIVE];

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			memory_data_pins_oe_o <= '0;
		end else begin
			memory_data_pins_oe_o <= {PIN_COUNT{pins_drive}};
		end
	end

	// Upper pads keep the last driven word, lower ones follow the source
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			memory_data_pins_o <= '0;
		end else begin
			memory_data_pins_o[HOLD_FROM-1:0] <= mem_out_i[HOLD_FROM-1:0];
			if (pins_drive) begin
				memory_data_pins_o[PIN_COUNT-1:HOLD_FROM] <=
					mem_out_i[PIN_COUNT-1:HOLD_FROM];
			end
		end
	end

	// ****************************************************************
	// Pin fifty and write timing
	// ****************************************************************
	logic legacy_connector;
	logic next_pin_fifty;

	assign legacy_connector = connector_sync_control[vsx_pkg::B_CONN_EN]
		&& !connector_sync_control[vsx_pkg::B_CONN_TYPE];

	always_comb begin
		if (memory_pin_write_control[vsx_pkg::B_PIN50]) begin
			next_pin_fifty = second_row_strobe_i;
		end else if (!edo_memory_i) begin
			next_pin_fifty = output_enable_zero_i;
		end else if (legacy_connector) begin
			next_pin_fifty = 1'b1;
		end else begin
			next_pin_fifty = output_enable_one_i;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			pin_fifty_o <= 1'b1;
			write_cycle_clocks_o <= vsx_pkg::WR_CLKS_SLOW;
		end else begin
			pin_fifty_o <= next_pin_fifty;
			write_cycle_clocks_o <=
				memory_pin_write_control[vsx_pkg::B_FAST_WR]
				? vsx_pkg::WR_CLKS_FAST : vsx_pkg::WR_CLKS_SLOW;
		end
	end

	// ****************************************************************
	// Feature connector colour and clocking
	// ****************************************************************
	logic [3:0] fmt_code;
	logic fmt_reserved;

	assign fmt_code = connector_color_mode[vsx_pkg::B_FMT_HI:
		vsx_pkg::B_FMT_LO];

	always_comb begin
		case (fmt_code)
			vsx_pkg::FMT_8BIT_1PIX,
			vsx_pkg::FMT_8BIT_2PIX,
			vsx_pkg::FMT_15BIT,
			vsx_pkg::FMT_16BIT,
			vsx_pkg::FMT_PACKED_24,
			vsx_pkg::FMT_24BIT: fmt_reserved = 1'b0;
			default: fmt_reserved = 1'b1;
		endcase
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			external_dot_clock_test_o <= 1'b0;
			connector_latch_clock_select_o <= 1'b0;
			packed_truecolor_active_o <= 1'b0;
			connector_pixel_format_o <= vsx_pkg::FMT_8BIT_1PIX;
			connector_format_reserved_o <= 1'b0;
		end else begin
			external_dot_clock_test_o <=
				connector_color_mode[vsx_pkg::B_DOT_EXT];
			connector_latch_clock_select_o <=
				connector_color_mode[vsx_pkg::B_LATCH_EXT];
			packed_truecolor_active_o <=
				connector_color_mode[vsx_pkg::B_PACKED]
				&& fmt_code == vsx_pkg::FMT_PACKED_24
				&& pixel_mode_i == vsx_pkg::PIXMODE_PLAIN;
			connector_pixel_format_o <= fmt_code;
			connector_format_reserved_o <= fmt_reserved;
		end
	end

	// ****************************************************************
	// Feature connector pins and type
	// ****************************************************************
	logic conn_on;

	assign conn_on = connector_sync_control[vsx_pkg::B_CONN_EN];

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			connector_enable_pin_o <= 1'b1;
			video_clock_out_en_o <= 1'b1;
			sync_out_en_o <= 1'b1;
			connector_type_select_o <= 1'b0;
		end else begin
			connector_enable_pin_o <= !conn_on;
			video_clock_out_en_o <= !conn_on
				|| clock_direction_input_i;
			sync_out_en_o <= !conn_on
				|| sync_direction_input_i;
			connector_type_select_o <= conn_on && !local_peripheral_bus_i
				&& connector_sync_control[vsx_pkg::B_CONN_TYPE];
		end
	end

	// ****************************************************************
	// Sync forcing
	// ****************************************************************
	vsx_sync_force u_hsync (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.ctl_i(connector_sync_control[vsx_pkg::B_HS_HI:vsx_pkg::B_HS_LO]),
		.sync_i(hsync_i),
		.sync_o(hsync_o)
	);

	vsx_sync_force u_vsync (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.ctl_i(connector_sync_control[vsx_pkg::B_VS_HI:vsx_pkg::B_VS_LO]),
		.sync_i(vsync_i),
		.sync_o(vsync_o)
	);

	// ****************************************************************
	// Memory clock PLL low byte
	// ****************************************************************
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			pll_in_div_o <= PLL_LOW_RESET[vsx_pkg::B_DIV_HI:0];
			pll_range_o <= PLL_LOW_RESET[vsx_pkg::B_RANGE_HI:
				vsx_pkg::B_RANGE_LO];
		end else if (freq_load_i || immediate_load_i) begin
			pll_in_div_o <= memclk_pll_low[vsx_pkg::B_DIV_HI:0];
			pll_range_o <= memclk_pll_low[vsx_pkg::B_RANGE_HI:
				vsx_pkg::B_RANGE_LO];
		end
	end

endmodule
`default_nettype wire

// ===== bench/vsx_host.sv
`default_nettype none
module vsx_host (
	input wire logic clock_i,       // Clock
	input wire logic [7:0] rdata_i, // Read data
	input wire logic rvalid_i,      // Read valid
	output logic wr_o,              // Write strobe
	output logic rd_o,              // Read strobe
	output logic port_o,            // Data port
	output logic word_o,            // Word write
	output logic [7:0] lo_o,        // Low byte
	output logic [7:0] hi_o         // High byte
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {wr_o, rd_o, port_o, word_o, lo_o, hi_o} = '0;
	task automatic put(input logic p, w, input logic [7:0] l, h);
		@(posedge clock_i);
		#1 {wr_o, port_o, word_o, lo_o, hi_o} = {1'b1, p, w, l, h};
		@(posedge clock_i);
		#1 {wr_o, word_o, lo_o, hi_o} = {2'b00, ~l, ~h};
	endtask
	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		put(0, 0, {3'h0, i}, 8'h00);
		put(1, 0, d, 8'h00);
	endtask
	task automatic rd(input logic [4:0] i, output logic [7:0] d);
		put(0, 0, {3'h0, i}, 8'h00);
		@(posedge clock_i);
		#1 {rd_o, port_o} = 2'b11;
		@(posedge clock_i);
		#1 rd_o = 0;
		d = rvalid_i ? rdata_i : 8'hXX;
	endtask
endmodule
`default_nettype wire

// ===== bench/vsx_chk.sv
`default_nettype none
module vsx_chk #(parameter int PIN_COUNT = 64, parameter int HOLD_FROM = 29) (
	input wire logic clock_i,                   // Clock
	input wire logic reset_i,                   // Reset
	input wire logic io_read_i,                 // Read
	input wire logic io_rvalid_o,               // Read valid
	input wire logic attr_bit3_i,               // Attribute bit
	input wire logic [2:0] font_region_o,       // Region
	input wire logic font_intensity_o,          // Intensity
	input wire logic full_memory_access_o,      // Full memory
	input wire logic mem_out_req_i,             // Output needed
	input wire logic [PIN_COUNT-1:0] memory_data_pins_o, // Pins
	input wire logic [PIN_COUNT-1:0] memory_data_pins_oe_o, // Enables
	input wire logic [1:0] write_cycle_clocks_o, // Write clocks
	input wire logic freq_load_i,               // Load
	input wire logic immediate_load_i,          // Load now
	input wire logic [4:0] pll_in_div_o,        // Divider
	input wire logic [1:0] pll_range_o,         // Range
	input wire logic connector_enable_pin_o,    // Enable pin
	input wire logic video_clock_out_en_o,      // Clock out
	input wire logic sync_out_en_o              // Sync out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence s_rd;
		io_read_i;
	endsequence
	AST_RVALID: assert property (s_rd |=> io_rvalid_o)
		else $error("read gave no valid");
	AST_WRCLK: assert property (write_cycle_clocks_o inside {2'h2, 2'h3})
		else $error("bad write clocks");
	AST_OE: assert property (mem_out_req_i |=> &memory_data_pins_oe_o)
		else $error("pins not driven");
	AST_HOLD: assert property (!memory_data_pins_oe_o[PIN_COUNT-1] |->
		$stable(memory_data_pins_o[PIN_COUNT-1:HOLD_FROM]))
		else $error("upper pins lost value");
	AST_PLL: assert property (!freq_load_i && !immediate_load_i |=>
		$stable({pll_in_div_o, pll_range_o}))
		else $error("pll loaded unasked");
	AST_CONN: assert property (connector_enable_pin_o |->
		video_clock_out_en_o && sync_out_en_o)
		else $error("connector off but not outputs");
	AST_INT: assert property (font_intensity_o |-> $past(attr_bit3_i))
		else $error("intensity without bit");
	AST_FULL: assert property (!full_memory_access_o ##1
		!full_memory_access_o |-> font_region_o[1:0] == 2'h0)
		else $error("font region not limited");
endmodule
bind vsx_seq_regs vsx_chk #(.PIN_COUNT(PIN_COUNT), .HOLD_FROM(HOLD_FROM))
	vsx_chk_i (.*);
`default_nettype wire

// ===== bench/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [4:0] i; logic [7:0] m, r;} vsx_row_s;
	localparam logic [7:0] PLL_RST = 8'h01; // Arbitrary start value
	logic clock_i, reset_i, io_write_i, io_read_i, io_data_port_i, io_word_i;
	logic io_mapped_i, mapped_enable_i, io_rvalid_o, text_mode_i, attr_bit3_i;
	logic cpu_write_i, mem_out_req_i, edo_memory_i, output_enable_zero_i;
	logic output_enable_one_i, second_row_strobe_i, clock_direction_input_i;
	logic sync_direction_input_i, local_peripheral_bus_i, hsync_i, vsync_i;
	logic freq_load_i, immediate_load_i, hsync_o, vsync_o, font_intensity_o;
	logic pin_fifty_o;
	logic [7:0] io_wdata_i, io_wdata_hi_i, io_rdata_o, v;
	logic [1:0] cpu_addr_i, write_cycle_clocks_o, pll_range_o;
	logic [2:0] font_region_o;
	logic [3:0] pixel_mode_i, plane_select_o;
	logic [4:0] pll_in_div_o;
	logic [63:0] mem_out_i, memory_data_pins_o, memory_data_pins_oe_o;
	int error_cnt, comparisons;
	vsx_row_s rows [10] = '{'{5'h03, 8'h3F, 8'h00}, '{5'h04, 8'h0E, 8'h00},
		'{5'h08, 8'hFF, 8'h06}, '{5'h09, 8'h80, 8'h00}, '{5'h0A, 8'hE0, 8'h00},
		'{5'h0B, 8'hFB, 8'h00}, '{5'h0D, 8'hF3, 8'h00}, '{5'h10, 8'h7F, 8'h01},
		'{5'h05, 8'h00, 8'h00}, '{5'h1C, 8'h00, 8'h00}};
	vsx_host host_i (.clock_i, .rdata_i(io_rdata_o), .rvalid_i(io_rvalid_o),
		.wr_o(io_write_i), .rd_o(io_read_i), .port_o(io_data_port_i),
		.word_o(io_word_i), .lo_o(io_wdata_i), .hi_o(io_wdata_hi_i));
	vsx_seq_regs #(.PLL_LOW_RESET(PLL_RST)) vsx_seq_regs_i (.*,
		.full_memory_access_o(), .external_dot_clock_test_o(),
		.connector_latch_clock_select_o(), .packed_truecolor_active_o(),
		.connector_pixel_format_o(), .connector_format_reserved_o(),
		.connector_enable_pin_o(), .video_clock_out_en_o(), .sync_out_en_o(),
		.connector_type_select_o());
	task automatic chk(input logic [63:0] s, e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	task automatic step;
		repeat (2) @(posedge clock_i);
		#1;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		clock_i = 0;
		forever #4 clock_i = ~clock_i;
	end
	initial begin
		#100000 error_cnt++;
		end_sim;
	end
	initial begin
		{io_mapped_i, mapped_enable_i, text_mode_i, attr_bit3_i, cpu_write_i,
			mem_out_req_i, edo_memory_i, output_enable_zero_i, output_enable_one_i,
			second_row_strobe_i, clock_direction_input_i, sync_direction_input_i,
			local_peripheral_bus_i, hsync_i, vsync_i, freq_load_i,
			immediate_load_i, cpu_addr_i, pixel_mode_i, mem_out_i} = '0;
		reset_i = 1;
		repeat (16) @(posedge clock_i);
		#1 reset_i = 0;
		host_i.wr(5'h08, 8'h06);
		foreach (rows[k]) begin
			host_i.rd(rows[k].i, v);
			chk(v, rows[k].r);
			host_i.wr(rows[k].i, rows[k].i == 5'h08 ? 8'hF6 : 8'hFF);
			host_i.rd(rows[k].i, v);
			chk(v, (rows[k].i == 5'h08 ? 8'hF6 : 8'hFF) & rows[k].m);
		end
		$display("end table");
		host_i.wr(5'h08, 8'hF0);
		host_i.rd(5'h0A, v);
		chk(v, 8'h00);
		host_i.wr(5'h08, 8'h36);
		host_i.rd(5'h0A, v);
		chk(v, 8'hE0);
		mapped_enable_i = 1;
		host_i.rd(5'h0A, v);
		chk(v, 8'h00);
		io_mapped_i = 1;
		host_i.rd(5'h0A, v);
		chk(v, 8'hE0);
		host_i.wr(5'h09, 8'h00);
		{io_mapped_i, mapped_enable_i} = 2'b00;
		host_i.put(0, 1, 8'h0D, 8'h12);
		host_i.rd(5'h0D, v);
		chk(v, 8'h12);
		$display("end access");
		for (int c = 0; c < 4; c++) begin
			host_i.wr(5'h0D, {c[1:0], c[1:0], 4'h0});
			{hsync_i, vsync_i} = {2{~c[1]}};
			step;
			chk({hsync_o, vsync_o}, {2{~c[0]}});
		end
		host_i.wr(5'h04, 8'h08);
		for (int a = 0; a < 4; a++) begin
			cpu_addr_i = a[1:0];
			step;
			chk(plane_select_o, 4'h1 << a);
		end
		host_i.wr(5'h04, 8'h04);
		cpu_write_i = 1;
		step;
		chk(plane_select_o, 4'hF);
		cpu_write_i = 0;
		step;
		chk(plane_select_o, 4'hA);
		$display("end sync planes");
		host_i.wr(5'h04, 8'h02);
		host_i.wr(5'h03, 8'h32);
		{text_mode_i, attr_bit3_i} = 2'b11;
		step;
		chk({font_region_o, font_intensity_o}, 4'hA);
		attr_bit3_i = 0;
		step;
		chk({font_region_o, font_intensity_o}, 4'h2);
		host_i.wr(5'h04, 8'h00);
		attr_bit3_i = 1;
		step;
		chk(font_region_o, 3'h4);
		host_i.wr(5'h03, 8'h00);
		step;
		chk({font_region_o, font_intensity_o}, 4'h1);
		$display("end font");
		chk(write_cycle_clocks_o, 2'h2);
		host_i.wr(5'h0A, 8'h00);
		{mem_out_req_i, mem_out_i} = {1'b1, 64'hFFFF_FFFF_FFFF_FFFF};
		step;
		chk(write_cycle_clocks_o, 2'h3);
		chk(memory_data_pins_oe_o & memory_data_pins_o, '1);
		{mem_out_req_i, mem_out_i} = '0;
		step;
		chk(memory_data_pins_oe_o, '0);
		chk(memory_data_pins_o, 64'hFFFF_FFFF_E000_0000);
		for (int k = 0; k < 16; k++) begin
			{edo_memory_i, output_enable_zero_i, output_enable_one_i,
				second_row_strobe_i} = k[3:0];
			step;
			chk(pin_fifty_o, k[3] ? k[1] : k[2]);
		end
		chk({pll_range_o, pll_in_div_o}, PLL_RST[6:0]);
		freq_load_i = 1;
		step;
		chk({pll_range_o, pll_in_div_o}, 7'h7F);
		$display("end pins pll");
		host_i.wr(5'h03, 8'h3F);
		reset_i = 1;
		#2 chk(font_region_o, 3'h0);
		@(posedge clock_i);
		#1 reset_i = 0;
		host_i.rd(5'h03, v);
		chk(v, 8'h00);
		$display("end reset");
		end_sim;
	end
endmodule
`default_nettype wire
